// File: spoc_params.svh
`ifndef SPOC_PARAMS_SVH
`define SPOC_PARAMS_SVH

// ---------------------------------------------------------------------------
// Pin bus layout
// ---------------------------------------------------------------------------
`define SPOC_BUS_WR       33
`define SPOC_BUS_ACK      32
`define SPOC_TGT_HI       1
`define SPOC_TGT_LO       0
`define SPOC_RES_FLAG     32

// ---------------------------------------------------------------------------
// Mode word fields
// ---------------------------------------------------------------------------
`define SPOC_SEL_HI       5
`define SPOC_SEL_LO       1
`define SPOC_TT_HI        7
`define SPOC_TT_LO        6
`define SPOC_DACSEL_HI    20
`define SPOC_DACSEL_LO    18
`define SPOC_DAC_CODE     3'h5
`define SPOC_LVL_HI       15
`define SPOC_LVL_LO       8
`define SPOC_NIBH_HI      15
`define SPOC_NIBH_LO      12
`define SPOC_NIBL_HI      11
`define SPOC_NIBL_LO      8
`define SPOC_CLKD_BIT     16
`define SPOC_INV_IN_BIT   15
`define SPOC_INV_OUT_BIT  14

// ---------------------------------------------------------------------------
// Codes and reset values
// ---------------------------------------------------------------------------
`define SPOC_SEL_OFF      5'h00
`define SPOC_SEL_DAC_LAST 5'h03
`define SPOC_RST_WORD     32'h0000_0000
`define SPOC_RST_LVL      8'h00
`define SPOC_RST_CHAN     4'h0
`define SPOC_LFSR_W       16
`define SPOC_LFSR_TAPS    16'hB400
`define SPOC_SEED_BASE    16'hACE1

`endif

// File: spoc_pkg.sv
package spoc_pkg;

  typedef enum logic {
    SPOC_BUS_IDLE = 1'h0,
    SPOC_BUS_DATA = 1'h1
  } spoc_bus_st_t;

  typedef enum logic [1:0] {
    SPOC_TGT_NONE = 2'h0,
    SPOC_TGT_MODE = 2'h1,
    SPOC_TGT_X    = 2'h2,
    SPOC_TGT_Y    = 2'h3
  } spoc_tgt_t;

  typedef enum logic [1:0] {
    SPOC_TT_00 = 2'h0,
    SPOC_TT_01 = 2'h1,
    SPOC_TT_10 = 2'h2,
    SPOC_TT_11 = 2'h3
  } spoc_tt_t;

endpackage

// File: spoc_noise_if.sv
`timescale 1ns/100ps
interface spoc_noise_if;
  logic run;
  logic noise_bit;

  modport src (
    input  run,
    output noise_bit
  );

  modport snk (
    output run,
    input  noise_bit
  );
endinterface

// File: spoc_lfsr.sv
`timescale 1ns/100ps
`include "spoc_params.svh"

module spoc_lfsr #(
  parameter logic [`SPOC_LFSR_W-1:0] SEED = `SPOC_SEED_BASE
) (
  input wire logic   clk,
  input wire logic   arst_n,
  spoc_noise_if.src  nz
);

  logic [`SPOC_LFSR_W-1:0] state_q;

  // ---------------------------------------------------------------------------
  // Galois shift register, advances only while run is high
  // ---------------------------------------------------------------------------
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state_q <= SEED;
    end else if (nz.run) begin
      if (state_q[0]) begin
        state_q <= (state_q >> 1) ^ `SPOC_LFSR_TAPS;
      end else begin
        state_q <= state_q >> 1;
      end
    end
  end

  assign nz.noise_bit = state_q[0];

endmodule // spoc_lfsr

// File: spoc_smart_pin.sv
// What this block does
// - Odd pin companion is even partner inverted
// - Even pin companion is per-pin noise bit
// - Codes 4-31: smart output overrides latch and companion while smart_drive is high
// - Mode bits 20:18 equal 101 mean DAC
// - Off, no DAC: direction enables, TT picks source
// - Off, DAC: 00 level, 10 latch, 11 companion
// - Off, DAC, 01: latch enables ADC, channel
// - Smart on: TT bit 0 alone sets enable, except codes 1-3 in DAC
// - Codes 1-3: latch/companion enable DAC, smart level
// - Codes 4-31: smart merged drive, nibble in DAC
// - Even pin pairs with the next odd pin
// - Smart on: direction is active-low smart reset
// - Codes 4-31 ignore the output latch while smart_drive is high
// - Smart on: input flag reports events
// - Mode, X, Y write-only; result read-only
// - Two-clock accesses, 32-bit data word
// - Write-ack and read-ack acknowledge; quiet read not
// - 34-bit input bus, 33-bit output bus
// - Clocked input path updates on edges only
// - Direction 0 floats, 1 drives, when off outside DAC
// - Acknowledge drops the flag two clocks later
`timescale 1ns/100ps
`include "spoc_params.svh"

module spoc_smart_pin #(
  parameter logic [5:0] PIN_NUM = 6'h00
) (
  input  wire logic        clk,
  input  wire logic        arst_n,
  input  wire logic [33:0] pin_bus_in,
  output logic      [32:0] pin_bus_out,
  input  wire logic        dir_bit,
  input  wire logic        out_bit,
  input  wire logic        pad_in,
  input  wire logic        partner_out,
  input  wire logic        smart_out,
  input  wire logic        smart_drive,
  input  wire logic [7:0]  smart_dac_level,
  input  wire logic        smart_event,
  input  wire logic [31:0] smart_result,
  output logic             pad_out,
  output logic             pad_oe,
  output logic             dac_en,
  output logic      [7:0]  dac_level,
  output logic             adc_en,
  output logic      [3:0]  adc_chan,
  output logic             in_flag,
  output logic             own_out,
  output logic             smart_rst_n,
  output logic      [31:0] pin_mode_config_q,
  output logic      [31:0] first_parameter_q,
  output logic      [31:0] second_parameter_q
);

  // ---------------------------------------------------------------------------
  // Declarations
  // ---------------------------------------------------------------------------
  spoc_pkg::spoc_bus_st_t bus_st_q;
  spoc_pkg::spoc_tgt_t    tgt_q;
  spoc_pkg::spoc_tt_t     tt;
  logic [4:0]             func_sel;
  logic                   smart_on;
  logic                   dac_mode;
  logic                   dac_smart;
  logic                   other_bit;
  logic                   pad_s1_q;
  logic                   pad_s2_q;
  logic                   pad_clk_q;
  logic                   pin_state;
  logic                   ack_q;
  logic                   ack_q2;
  logic                   flag_q;
  logic                   pad_out_d;
  logic                   pad_oe_d;
  logic                   dac_en_d;
  logic [7:0]             dac_level_d;
  logic                   adc_en_d;
  logic [3:0]             adc_chan_d;
  logic                   in_flag_d;
  logic                   drive_bit;

  spoc_noise_if nz ();

  // ---------------------------------------------------------------------------
  // Noise source, only meaningful on even pins
  // ---------------------------------------------------------------------------
  assign nz.run = ~PIN_NUM[0];

  spoc_lfsr #(
    .SEED (`SPOC_SEED_BASE ^ {10'h000, PIN_NUM})
  ) u_noise (
    .clk    (clk),
    .arst_n (arst_n),
    .nz     (nz.src)
  );

  // ---------------------------------------------------------------------------
  // Mode word decode
  // ---------------------------------------------------------------------------
  assign func_sel = pin_mode_config_q[`SPOC_SEL_HI:`SPOC_SEL_LO];
  assign tt = spoc_pkg::spoc_tt_t'(
                pin_mode_config_q[`SPOC_TT_HI:`SPOC_TT_LO]);
  assign smart_on = (func_sel != `SPOC_SEL_OFF);
  assign dac_mode = (pin_mode_config_q[`SPOC_DACSEL_HI:`SPOC_DACSEL_LO]
                     == `SPOC_DAC_CODE);
  assign dac_smart = smart_on && (func_sel <= `SPOC_SEL_DAC_LAST);

  // Partner is the adjacent pin of the pair; the outside joins 2n to 2n+1
  assign other_bit = PIN_NUM[0] ? ~partner_out
                                : nz.noise_bit;

  // ---------------------------------------------------------------------------
  // Register access over the pin bus
  // ---------------------------------------------------------------------------
  // Cycle 0 carries the write strobe and target, cycle 1 the data word.
  // Several cores OR onto this bus, so a stray strobe during the data
  // cycle is taken as data, not as a new command.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      bus_st_q <= spoc_pkg::SPOC_BUS_IDLE;
      tgt_q    <= spoc_pkg::SPOC_TGT_NONE;
    end else begin
      unique case (bus_st_q)
        spoc_pkg::SPOC_BUS_IDLE: begin
          if (pin_bus_in[`SPOC_BUS_WR]) begin
            bus_st_q <= spoc_pkg::SPOC_BUS_DATA;
            tgt_q    <= spoc_pkg::spoc_tgt_t'(
                          pin_bus_in[`SPOC_TGT_HI:`SPOC_TGT_LO]);
          end
        end
        spoc_pkg::SPOC_BUS_DATA: begin
          bus_st_q <= spoc_pkg::SPOC_BUS_IDLE;
          tgt_q    <= spoc_pkg::SPOC_TGT_NONE;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pin_mode_config_q  <= `SPOC_RST_WORD;
      first_parameter_q  <= `SPOC_RST_WORD;
      second_parameter_q <= `SPOC_RST_WORD;
    end else if (bus_st_q == spoc_pkg::SPOC_BUS_DATA) begin
      unique case (tgt_q)
        spoc_pkg::SPOC_TGT_MODE: begin
          pin_mode_config_q <= pin_bus_in[31:0];
        end
        spoc_pkg::SPOC_TGT_X: begin
          first_parameter_q <= pin_bus_in[31:0];
        end
        spoc_pkg::SPOC_TGT_Y: begin
          second_parameter_q <= pin_bus_in[31:0];
        end
        spoc_pkg::SPOC_TGT_NONE: begin
        end
      endcase
    end
  end

  // Result and special flag are presented continuously; a quiet read
  // is just a look at this bus and so never touches the event flag.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pin_bus_out <= {1'h0, `SPOC_RST_WORD};
    end else begin
      pin_bus_out[31:0] <= smart_result;
      pin_bus_out[`SPOC_RES_FLAG] <= smart_on ? flag_q
                                              : smart_result[31];
    end
  end

  // ---------------------------------------------------------------------------
  // Acknowledge and event flag
  // ---------------------------------------------------------------------------
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ack_q  <= 1'h0;
      ack_q2 <= 1'h0;
    end else begin
      ack_q  <= (bus_st_q == spoc_pkg::SPOC_BUS_IDLE)
                && pin_bus_in[`SPOC_BUS_ACK];
      ack_q2 <= ack_q;
    end
  end

  // A fresh event in the clearing cycle wins, so no event is lost
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      flag_q <= 1'h0;
    end else if (!smart_on || !dir_bit) begin
      flag_q <= 1'h0;
    end else if (smart_event) begin
      flag_q <= 1'h1;
    end else if (ack_q2) begin
      flag_q <= 1'h0;
    end
  end

  // ---------------------------------------------------------------------------
  // Pad input path
  // ---------------------------------------------------------------------------
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pad_s1_q  <= 1'h0;
      pad_s2_q  <= 1'h0;
      pad_clk_q <= 1'h0;
    end else begin
      pad_s1_q  <= pad_in;
      pad_s2_q  <= pad_s1_q;
      pad_clk_q <= pad_s2_q;
    end
  end

  // Live path still passes the synchroniser; only the extra stage goes
  assign pin_state = (pin_mode_config_q[`SPOC_CLKD_BIT] ? pad_clk_q
                                                        : pad_s2_q)
                     ^ pin_mode_config_q[`SPOC_INV_IN_BIT];

  // ---------------------------------------------------------------------------
  // Output source selection
  // ---------------------------------------------------------------------------
  // In codes 4-31, smart output wins whenever the function claims the drive
  assign drive_bit = smart_drive ? smart_out
                                 : (tt[1] ? other_bit : out_bit);

  always_comb begin
    pad_out_d   = 1'h0;
    pad_oe_d    = 1'h0;
    dac_en_d    = 1'h0;
    dac_level_d = `SPOC_RST_LVL;
    adc_en_d    = 1'h0;
    adc_chan_d  = `SPOC_RST_CHAN;
    in_flag_d   = pin_state;
    if (!smart_on) begin
      if (!dac_mode) begin
        pad_oe_d  = dir_bit;
        pad_out_d = (tt[1] ? other_bit : out_bit)
                    ^ pin_mode_config_q[`SPOC_INV_OUT_BIT];
      end else begin
        unique case (tt)
          spoc_pkg::SPOC_TT_00: begin
            dac_en_d    = dir_bit;
            dac_level_d = pin_mode_config_q[`SPOC_LVL_HI:`SPOC_LVL_LO];
          end
          spoc_pkg::SPOC_TT_01: begin
            adc_en_d   = out_bit;
            adc_chan_d = pin_mode_config_q[`SPOC_NIBL_HI:`SPOC_NIBL_LO];
          end
          spoc_pkg::SPOC_TT_10: begin
            dac_en_d    = dir_bit;
            dac_level_d = nibble_level(out_bit);
          end
          spoc_pkg::SPOC_TT_11: begin
            dac_en_d    = dir_bit;
            dac_level_d = nibble_level(other_bit);
          end
        endcase
      end
    end else begin
      in_flag_d = flag_q;
      if (dac_smart && dac_mode) begin
        dac_en_d    = tt[1] ? other_bit : out_bit;
        dac_level_d = smart_dac_level;
      end else if (dac_mode) begin
        dac_en_d    = tt[0];
        dac_level_d = nibble_level(drive_bit);
      end else begin
        pad_oe_d  = tt[0];
        pad_out_d = (dac_smart ? (tt[1] ? other_bit : out_bit)
                               : drive_bit)
                    ^ pin_mode_config_q[`SPOC_INV_OUT_BIT];
      end
    end
  end

  // Doubled nibble keeps the full 8-bit scale from a 4-bit setting
  function automatic logic [7:0] nibble_level(input logic hi);
    logic [3:0] nib;
    nib = hi ? pin_mode_config_q[`SPOC_NIBH_HI:`SPOC_NIBH_LO]
             : pin_mode_config_q[`SPOC_NIBL_HI:`SPOC_NIBL_LO];
    return {nib, nib};
  endfunction

  // ---------------------------------------------------------------------------
  // Registered outputs
  // ---------------------------------------------------------------------------
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pad_out   <= 1'h0;
      pad_oe    <= 1'h0;
      dac_en    <= 1'h0;
      dac_level <= `SPOC_RST_LVL;
      adc_en    <= 1'h0;
      adc_chan  <= `SPOC_RST_CHAN;
      in_flag   <= 1'h0;
      own_out   <= 1'h0;
    end else begin
      pad_out   <= pad_out_d;
      pad_oe    <= pad_oe_d;
      dac_en    <= dac_en_d;
      dac_level <= dac_level_d;
      adc_en    <= adc_en_d;
      adc_chan  <= adc_chan_d;
      in_flag   <= in_flag_d;
      own_out   <= pad_out_d;
    end
  end

  // Holding direction low keeps the function in reset while the core
  // loads mode and parameters; the core is trusted to do so first.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      smart_rst_n <= 1'h0;
    end else begin
      smart_rst_n <= smart_on && dir_bit;
    end
  end

endmodule // spoc_smart_pin

// File: spoc_smart_pin_sva.sv
`timescale 1ns/100ps
module spoc_smart_pin_sva #(
  parameter logic [5:0] PIN_NUM = 6'h00
) (
  input wire logic        clk,
  input wire logic        arst_n,
  input wire logic [33:0] pin_bus_in,
  input wire logic [32:0] pin_bus_out,
  input wire logic        dir_bit,
  input wire logic        out_bit,
  input wire logic        partner_out,
  input wire logic        smart_event,
  input wire logic [31:0] smart_result,
  input wire logic        pad_out,
  input wire logic        pad_oe,
  input wire logic [7:0]  dac_level,
  input wire logic        in_flag,
  input wire logic        smart_rst_n,
  input wire logic [31:0] pin_mode_config_q
);
  // ----------------------------------------------------------------
  // Decoded mode and bus phase
  // ----------------------------------------------------------------
  logic [31:0] m;
  logic [31:0] word;
  logic        data_q;
  logic        dac;
  logic        off;
  logic        take;
  assign m    = pin_mode_config_q;
  assign word = pin_bus_in[31:0];
  assign dac  = m[20:18] == 3'h5;
  assign off  = m[5:1] == 5'h00;
  // A strobe seen in the data cycle is payload, not a new request
  assign take = !data_q && pin_bus_in[33];
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) data_q <= 1'b0;
    else data_q <= take;
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  property p_wr;
    take && pin_bus_in[1:0] == 2'h1 |-> ##3 m == $past(word, 2); endproperty
  a_wr: assert property (p_wr) else $error("mode not stored");
  property p_ack;
    !data_q && pin_bus_in[32] && !off && !smart_event ##1 !smart_event [*3]
      |-> ##1 !in_flag; endproperty
  a_ack: assert property (p_ack) else $error("flag kept");
  property p_oe;
    !off && !dac ##1 $stable(m) |-> pad_oe == m[6]; endproperty
  a_oe: assert property (p_oe) else $error("smart enable");
  property p_rst; dir_bit && !off |=> smart_rst_n; endproperty
  a_rst: assert property (p_rst) else $error("smart reset");
  property p_off;
    off && !dac && !m[7] && !m[14]
      |=> pad_out == $past(out_bit) && pad_oe == $past(dir_bit); endproperty
  a_off: assert property (p_off) else $error("latch drive");
  property p_diff;
    off && !dac && m[7] && !m[14] && PIN_NUM[0]
      |=> pad_out != $past(partner_out); endproperty
  a_diff: assert property (p_diff) else $error("diff pair");
  property p_lvl;
    off && dac && m[7:6] == 2'h0 ##1 $stable(m) |-> dac_level == m[15:8];
  endproperty
  a_lvl: assert property (p_lvl) else $error("dac level");
  property p_nib;
    off && dac && m[7:6] == 2'h2 && out_bit ##1 $stable(m)
      |-> dac_level == {2{m[15:12]}}; endproperty
  a_nib: assert property (p_nib) else $error("nibble level");
  property p_res; 1'b1 |=> pin_bus_out[31:0] == $past(smart_result);
  endproperty
  a_res: assert property (p_res) else $error("result word");
  c_ack: cover property (!data_q && pin_bus_in[32] && !off);
  c_evt: cover property (smart_event && !off && dir_bit);
  c_nib: cover property (off && dac && m[7:6] == 2'h2);
endmodule  // spoc_smart_pin_sva

// File: spoc_core_model.sv
`timescale 1ns/100ps
module spoc_core_model (
  input  wire logic        clk,
  output logic      [33:0] pin_bus,
  output logic             dir_bit,
  output logic             out_bit
);
  // ----------------------------------------------------------------
  // Core side of the pin bus
  // ----------------------------------------------------------------
  initial begin
    pin_bus = 34'h0;
    dir_bit = 1'b0;
    out_bit = 1'b0;
  end
  // Strobe cycle then data cycle; the ORed bus idles at zero
  task automatic op(input logic [1:0] t, input logic a,
    input logic [31:0] d);
    @(posedge clk);
    pin_bus <= {1'b1, a, 30'h0, t};
    @(posedge clk);
    pin_bus <= {2'h0, d};
    @(posedge clk);
    pin_bus <= 34'h0;
  endtask
  // Function is held in reset while it is reconfigured
  task automatic setup(input logic [31:0] m, x, y);
    @(posedge clk);
    dir_bit <= 1'b0;
    op(2'h1, 1'b0, m);
    op(2'h2, 1'b0, x);
    op(2'h3, 1'b0, y);
  endtask
  task automatic pins(input logic d, o);
    @(posedge clk);
    dir_bit <= d;
    out_bit <= o;
  endtask
endmodule  // spoc_core_model

// File: smart_pin_output_control_tb.sv
`timescale 1ns/100ps
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin \
  error_cnt++; $display("[FAIL] t=%0t got=%0h exp=%0h", $time, g, e); \
  end end

bind spoc_smart_pin spoc_smart_pin_sva #(.PIN_NUM(PIN_NUM)) u_sva (
  .clk(clk), .arst_n(arst_n), .pin_bus_in(pin_bus_in),
  .pin_bus_out(pin_bus_out), .dir_bit(dir_bit), .out_bit(out_bit),
  .partner_out(partner_out), .smart_event(smart_event),
  .smart_result(smart_result), .pad_out(pad_out), .pad_oe(pad_oe),
  .dac_level(dac_level), .in_flag(in_flag), .smart_rst_n(smart_rst_n),
  .pin_mode_config_q(pin_mode_config_q));

module smart_pin_output_control_tb;
  logic        clk, arst_n, pad_in, partner_out, smart_out, smart_drive;
  logic        smart_event, dir_bit, out_bit, pad_out, pad_oe, dac_en;
  logic        adc_en, in_flag, own_out, smart_rst_n;
  logic        ev_out, ev_prev;
  logic [3:0]  adc_chan;
  logic [7:0]  smart_dac_level, dac_level;
  logic [15:0] got, e, msk;
  logic [31:0] smart_result, mode_q, x_q, y_q, m, x, y, r;
  logic [32:0] bus_out;
  logic [33:0] bus;
  int          error_cnt, checks_done, cyc, seed, flips;

  assign got = {pad_out, pad_oe, dac_en, adc_en, adc_chan, dac_level};
  spoc_core_model core (.clk(clk), .pin_bus(bus), .dir_bit(dir_bit),
    .out_bit(out_bit));
  spoc_smart_pin #(.PIN_NUM(6'h01)) dut (
    .clk(clk), .arst_n(arst_n), .pin_bus_in(bus), .pin_bus_out(bus_out),
    .dir_bit(dir_bit), .out_bit(out_bit), .pad_in(pad_in),
    .partner_out(partner_out), .smart_out(smart_out),
    .smart_drive(smart_drive), .smart_dac_level(smart_dac_level),
    .smart_event(smart_event), .smart_result(smart_result),
    .pad_out(pad_out), .pad_oe(pad_oe), .dac_en(dac_en),
    .dac_level(dac_level), .adc_en(adc_en), .adc_chan(adc_chan),
    .in_flag(in_flag), .own_out(own_out), .smart_rst_n(smart_rst_n),
    .pin_mode_config_q(mode_q), .first_parameter_q(x_q),
    .second_parameter_q(y_q));
  // Even partner of the pair, watched for its noise companion
  spoc_smart_pin #(.PIN_NUM(6'h00)) u_even (
    .clk(clk), .arst_n(arst_n), .pin_bus_in(bus), .pin_bus_out(),
    .dir_bit(dir_bit), .out_bit(out_bit), .pad_in(pad_in),
    .partner_out(own_out), .smart_out(smart_out),
    .smart_drive(smart_drive), .smart_dac_level(smart_dac_level),
    .smart_event(smart_event), .smart_result(smart_result),
    .pad_out(ev_out), .pad_oe(), .dac_en(), .dac_level(), .adc_en(),
    .adc_chan(), .in_flag(), .own_out(), .smart_rst_n(),
    .pin_mode_config_q(), .first_parameter_q(), .second_parameter_q());

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  task automatic give_verdict();
    if (error_cnt == 0 && checks_done > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  always @(posedge clk) begin
    cyc++;
    if (cyc == 6000) begin
      error_cnt++;
      give_verdict();
    end
  end

  // ----------------------------------------------------------------
  // Reference model: c is the companion bit, k marks defined outputs
  // ----------------------------------------------------------------
  function automatic logic [7:0] nib(input logic b, input logic [31:0] w);
    return b ? {2{w[15:12]}} : {2{w[11:8]}};
  endfunction

  function automatic logic [15:0] model(input logic [31:0] w,
    input logic o, d, c, output logic [15:0] k);
    logic [4:0] s;
    logic       b;
    s = w[5:1];
    b = w[7] ? c : o;
    if (s > 5'h03 && smart_drive) b = smart_out;
    model = 16'h0;
    k = 16'h20FF;
    if (w[20:18] != 3'h5) begin
      model[15:14] = {b ^ w[14], s == 5'h00 ? d : w[6]};
      k = 16'hC000;
    end else if (s == 5'h00 && w[7:6] == 2'h0) begin
      model[13] = d;
      model[7:0] = w[15:8];
    end else if (s == 5'h00 && w[7:6] == 2'h1) begin
      model[12:8] = {o, w[11:8]};
      k = 16'h1F00;
    end else if (s == 5'h00) begin
      model[13] = d;
      model[7:0] = nib(w[6] ? c : o, w);
    end else if (s < 5'h04) begin
      // Smart codes one to three put the function's level on the DAC
      model[13] = b;
      model[7:0] = smart_dac_level;
    end else begin
      model[13] = w[6];
      model[7:0] = nib(b, w);
    end
  endfunction

  initial begin
    seed = 40629;
    arst_n = 1'b0;
    {pad_in, partner_out, smart_out, smart_drive, smart_event} = 5'h00;
    smart_dac_level = 8'h00;
    smart_result = 32'h0;
    repeat (2) @(posedge clk);
    @(negedge clk);
    `CHK({pad_oe, in_flag, mode_q}, 34'h0);
    @(posedge clk);
    arst_n <= 1'b1;
    // Every function code under every control value, random pins
    for (int i = 0; i < 128; i++) begin
      m = $random(seed);
      r = $random(seed);
      m[7:1] = i[6:0];
      if (r[8]) m[20:18] = 3'h5;
      x = $random(seed);
      y = $random(seed);
      core.setup(m, x, y);
      {partner_out, smart_out, smart_drive, pad_in} <= r[3:0];
      smart_dac_level <= r[31:24];
      smart_result <= x;
      core.pins(r[4], r[5]);
      repeat (5) @(posedge clk);
      @(negedge clk);
      e = model(m, r[5], r[4], ~r[3], msk);
      `CHK(got & msk, e & msk);
      `CHK({mode_q, x_q, y_q}, {m, x, y});
      `CHK(bus_out[31:0], x);
      `CHK(own_out, e[15]);
      `CHK(smart_rst_n, r[4] && i[4:0] != 5'h00);
      if (i[4:0] == 5'h00 && m[20:18] != 3'h5)
        `CHK(in_flag, r[0] ^ m[15]);
    end
    // Event flag: write with ack to no target, write to X with ack, then a quiet read
    core.setup(32'h0000_0048, 32'h0, 32'h0);
    core.pins(1'b1, 1'b0);
    for (int k = 0; k < 3; k++) begin
      @(posedge clk);
      smart_event <= 1'b1;
      @(posedge clk);
      smart_event <= 1'b0;
      repeat (2) @(posedge clk);
      @(negedge clk);
      `CHK({in_flag, bus_out[32]}, 2'h3);
      if (k < 2) core.op({k[0], 1'b0}, 1'b1, 32'h0);
      repeat (3) @(posedge clk);
      @(negedge clk);
      `CHK(in_flag, k == 2);
    end
    // Even pin companion is its noise source: it must not sit still
    core.setup(32'h0000_0080, 32'h0, 32'h0);
    core.pins(1'b1, 1'b0);
    repeat (3) @(posedge clk);
    @(negedge clk);
    ev_prev = ev_out;
    flips = 0;
    repeat (32) begin
      @(negedge clk);
      flips += (ev_out != ev_prev);
      ev_prev = ev_out;
    end
    `CHK(flips > 4, 1'b1);
    give_verdict();
  end
endmodule  // smart_pin_output_control_tb
